// file: src/udl_pkg.sv
// Constants and carrier types of the USB device link control block
package udl_pkg;
  localparam int unsigned AW = 8;
  // Register byte offsets
  localparam logic [AW-1:0] OFF_IRQ_FLAG  = 8'h00;
  localparam logic [AW-1:0] OFF_IRQ_EN    = 8'h04;
  localparam logic [AW-1:0] OFF_LINK_CTRL = 8'h08;
  localparam logic [AW-1:0] OFF_NODE_ID   = 8'h0C;
  localparam logic [AW-1:0] OFF_LINK_STAT = 8'h10;
  localparam logic [AW-1:0] OFF_EP_ZERO   = 8'h14;
  // Interrupt flag bit positions
  localparam int unsigned FB_SOF   = 0;
  localparam int unsigned FB_RESET = 1;
  localparam int unsigned FB_WAKE  = 2;
  localparam int unsigned FB_IDLE  = 3;
  localparam int unsigned FB_FAULT = 4;
  localparam int unsigned FB_SETUP_OVERFLOW_FLAG  = 5;
  // Link control bit positions
  localparam int unsigned CB_FORCE_BUS_RESET   = 0;
  localparam int unsigned CB_FORCED_SLEEP  = 1;
  localparam int unsigned CB_REGULATOR_OFF   = 2;
  localparam int unsigned CB_RESUME = 3;
  localparam int unsigned CB_RSTSEEN = 6;
  localparam int unsigned CB_RSM    = 7;
  // Endpoint 0 done bit
  localparam int unsigned EB_DONE = 7;
  // Reset values and masks
  localparam logic [7:0] CTRL_RESET   = 8'h06;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [7:0] CTRL_SW_MASK = 8'h0F;
  localparam logic [7:0] CTRL_ST_MASK = 8'hC0;
  localparam logic [7:0] FLAG_MASK    = 8'h3F;
  localparam logic [7:0] EN_MASK      = 8'hBF;
  localparam logic [7:0] NODE_MASK    = 8'h7F;
  localparam logic [7:0] EP0_SW_MASK  = 8'h77;
  localparam logic [7:0] EP0_KEEP     = 8'h80;
  localparam logic [2:0] FAULT_NONE   = 3'h0;
  localparam logic [1:0] TOKEN_SETUP  = 2'h3;
  localparam logic [1:0] EP_INDEX0    = 2'h0;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  // Idle time before a sleep request
  localparam int unsigned IDLE_TIME_MS = 3;
  localparam int unsigned CLK_HZ       = 100000000;
  localparam int unsigned IDLE_CYCLES  = IDLE_TIME_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic       sof;
    logic       bus_reset;
    logic       resume_start;
    logic       resume_end;
    logic       activity;
    logic       idle;
    logic       ep0_ok;
    logic [1:0] ep0_token;
    logic       epn_ok;
    logic [1:0] epn_index;
    logic       epn_dir;
    logic       error;
    logic [2:0] err_code;
  } udl_link_ev_t;

  typedef struct packed {
    logic          en;
    logic [AW-1:0] addr;
    logic [7:0]    data;
  } udl_wr_t;
endpackage : udl_pkg

// file: src/udl_idle_watch.sv
// Bus idle watchdog that raises a sleep request
`timescale 1ns/10ps
`default_nettype none
module udl_idle_watch #(
  parameter int unsigned LIMIT = udl_pkg::IDLE_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic idle,
  input  wire logic arm,
  input  wire logic disarm,
  output logic      sleep_req
);
  localparam int unsigned CW = $clog2(LIMIT + 2);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic          armed;
  logic          fired;
  logic [CW-1:0] cnt;
  logic          next_armed;
  logic          next_fired;
  logic [CW-1:0] next_cnt;

  // Pulse on the first idle cycle beyond the limit
  assign sleep_req = armed && idle && !fired && (cnt == LIM); // R3

  always_comb begin
    next_armed = armed;
    next_fired = fired;
    next_cnt   = cnt;
    // Disarm wins: suspend keeps the watch off until rearmed
    if (disarm) begin
      next_armed = 1'b0; // R4
    end else if (arm) begin
      next_armed = 1'b1; // R4
    end
    if (!idle || !armed || arm) begin
      next_cnt   = '0;
      next_fired = 1'b0;
    end else if (sleep_req) begin
      next_fired = 1'b1;
    end else if (!fired) begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed <= 1'b1;
      fired <= 1'b0;
      cnt   <= '0;
    end else begin
      armed <= next_armed;
      fired <= next_fired;
      cnt   <= next_cnt;
    end
  end

  a_idle_disarm: assert property (@(posedge aclk) disable iff (!aresetn)
    disarm |=> !sleep_req) else $error("sleep request while disarmed"); // R4
endmodule : udl_idle_watch
`default_nettype wire

// file: src/udl_axil_slave.sv
// AXI4-Lite slave front end for the byte-wide register file
`timescale 1ns/10ps
`default_nettype none
module udl_axil_slave (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [udl_pkg::AW-1:0]   s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [udl_pkg::AW-1:0]   s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output udl_pkg::udl_wr_t              wr,
  input  wire logic                     wr_hit,
  output logic [udl_pkg::AW-1:0]        rd_addr,
  input  wire logic [7:0]               rd_data,
  input  wire logic                     rd_hit
);
  logic                   aw_have, w_have, w_lane;
  logic [udl_pkg::AW-1:0] aw_addr;
  logic [7:0]             w_data;
  logic                   next_aw_have, next_w_have, next_w_lane;
  logic [udl_pkg::AW-1:0] next_aw_addr;
  logic [7:0]             next_w_data;
  logic                   next_bvalid, next_rvalid;
  logic [1:0]             next_bresp, next_rresp;
  logic [31:0]            next_rdata;
  logic                   do_write;

  assign s_axi_awready = !aw_have;
  assign s_axi_wready  = !w_have;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_have && w_have && !s_axi_bvalid;
  assign rd_addr       = {s_axi_araddr[udl_pkg::AW-1:2], 2'b00};
  // Registers live in byte lane 0; other lanes are ignored
  assign wr.en   = do_write && w_lane;
  assign wr.addr = aw_addr;
  assign wr.data = w_data;

  always_comb begin
    next_aw_have = aw_have;
    next_aw_addr = aw_addr;
    next_w_have  = w_have;
    next_w_data  = w_data;
    next_w_lane  = w_lane;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = {s_axi_awaddr[udl_pkg::AW-1:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_have = 1'b1;
      next_w_data = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (do_write) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? udl_pkg::RESP_OKAY : udl_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = {24'h000000, rd_data};
      next_rresp  = rd_hit ? udl_pkg::RESP_OKAY : udl_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have      <= 1'b0;
      aw_addr      <= '0;
      w_have       <= 1'b0;
      w_data       <= 8'h00;
      w_lane       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else begin
      aw_have      <= next_aw_have;
      aw_addr      <= next_aw_addr;
      w_have       <= next_w_have;
      w_data       <= next_w_data;
      w_lane       <= next_w_lane;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end
endmodule : udl_axil_slave
`default_nettype wire

// file: src/udl_link_ctrl.sv
// USB device link control and status registers with AXI4-Lite access
// How it works
// R1: SETUP done on endpoint 0 while its done flag is set sets overrun only
// R2: Any bus error sets the fault flag
// R3: Bus idle for more than 3 ms sets the sleep request flag
// R4: Idle watch armed at USB reset, off from forced sleep to resume end
// R5: Activity during suspend sets the wake flag on its own interrupt line
// R6: Bus reset detection sets the reset flag
// R7: USB reset clears address and endpoint 0 controls
// R8: SOF token sets the start-of-frame flag
// R9: Software clears flags with one full-byte write, no read-modify-write
// R10: Flag and enable both set with global mask clear raises interrupt
// R11: Link control reads 06h after reset
// R12: Resume start and reset start are latched to explain a wake
// R13: Resume bit drives resume signalling; software clears it later
// R14: Regulator off bit powers down; wait 3 us after power-up
// R15: Forced sleep set by software, cleared by bus activity or software
// R16: Forced reset holds the link in reset; release raises reset flag
// R17: Node id holds a 7-bit address, top bit reads zero
// R18: Token kind bits keep the top two PID bits of the endpoint 0 token
// R19: Endpoint 1/2 transfers record direction and endpoint index
// R20: Fault code reports the error type, zero meaning none
// R21: Fault code clears when software clears the fault flag
// R22: Endpoint 0 done set per transfer; USB reset clears bits 6:4, 2:0
// R23: Software cannot set flags, only clear them
// R24: Transfer-ok flag is the OR of all endpoint done flags
// R25: Writing zero clears a flag, writing one leaves it
`timescale 1ns/10ps
`default_nettype none
module udl_link_ctrl #(
  parameter int unsigned IDLE_LIMIT = udl_pkg::IDLE_CYCLES
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [udl_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [udl_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire udl_pkg::udl_link_ev_t  link_ev,
  input  wire logic                   ep_other_done,
  input  wire logic                   irq_global_mask,
  output logic                        irq_usb,
  output logic                        irq_wake,
  output logic                        regulator_off,
  output logic                        resume_drive,
  output logic                        suspend_active,
  output logic                        link_reset,
  output logic [6:0]                  node_addr
);
  udl_pkg::udl_wr_t       wr;
  logic                   wr_hit;
  logic [udl_pkg::AW-1:0] rd_addr;
  logic [7:0]             rd_data;
  logic                   rd_hit;
  logic                   sleep_req;
  logic                   usb_reset_now;
  logic                   xfer_ok_flag;
  logic [7:0]             flag_view;
  logic [7:0]             pending;

  logic [7:0] flags;
  logic [7:0] enable;
  logic [7:0] ctrl;
  logic [7:0] node_id;
  logic [7:0] status;
  logic [7:0] ep0;

  logic [7:0] next_flags;
  logic [7:0] next_enable;
  logic [7:0] next_ctrl;
  logic [7:0] next_node_id;
  logic [7:0] next_status;
  logic [7:0] next_ep0;
  logic       next_link_reset;

  udl_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr            (wr),
    .wr_hit        (wr_hit),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_hit        (rd_hit)
  );

  // Forced sleep disarms; USB reset or resume end rearms
  udl_idle_watch #(
    .LIMIT (IDLE_LIMIT)
  ) u_idle (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .idle      (link_ev.idle),
    .arm       (usb_reset_now || link_ev.resume_end), // R4
    .disarm    (ctrl[udl_pkg::CB_FORCED_SLEEP]), // R4
    .sleep_req (sleep_req)
  );

  assign usb_reset_now = link_ev.bus_reset || ctrl[udl_pkg::CB_FORCE_BUS_RESET];
  assign xfer_ok_flag  = ep0[udl_pkg::EB_DONE] || ep_other_done; // R24
  assign flag_view     = {xfer_ok_flag, 1'b0, flags[5:0]};

  // Wake has its own line so it can bring the core out of halt
  assign pending  = flag_view & enable & {8{!irq_global_mask}}; // R10
  assign irq_usb  = |(pending & ~(8'h01 << udl_pkg::FB_WAKE)); // R10
  assign irq_wake = pending[udl_pkg::FB_WAKE]; // R5

  assign regulator_off  = ctrl[udl_pkg::CB_REGULATOR_OFF]; // R14
  assign resume_drive   = ctrl[udl_pkg::CB_RESUME]; // R13
  assign suspend_active = ctrl[udl_pkg::CB_FORCED_SLEEP];
  assign node_addr      = node_id[6:0];

  always_comb begin
    wr_hit = 1'b1;
    unique case (wr.addr)
      udl_pkg::OFF_IRQ_FLAG,
      udl_pkg::OFF_IRQ_EN,
      udl_pkg::OFF_LINK_CTRL,
      udl_pkg::OFF_NODE_ID,
      udl_pkg::OFF_EP_ZERO:   wr_hit = 1'b1;
      default:                wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 8'h00;
    unique case (rd_addr)
      udl_pkg::OFF_IRQ_FLAG:  rd_data = flag_view;
      udl_pkg::OFF_IRQ_EN:    rd_data = enable;
      udl_pkg::OFF_LINK_CTRL: rd_data = ctrl;
      udl_pkg::OFF_NODE_ID:   rd_data = node_id; // R17
      udl_pkg::OFF_LINK_STAT: rd_data = status;
      udl_pkg::OFF_EP_ZERO:   rd_data = ep0;
      default:                rd_hit  = 1'b0;
    endcase
  end

  always_comb begin
    next_flags   = flags;
    next_enable  = enable;
    next_ctrl    = ctrl;
    next_node_id = node_id;
    next_status  = status;
    next_ep0     = ep0;
    // Software first, hardware after: a set in the same cycle wins
    if (wr.en) begin
      unique case (wr.addr)
        udl_pkg::OFF_IRQ_FLAG:
          next_flags = flags & (wr.data | ~udl_pkg::FLAG_MASK); // R23 R25
        udl_pkg::OFF_IRQ_EN:
          next_enable = wr.data & udl_pkg::EN_MASK;
        udl_pkg::OFF_LINK_CTRL:
          next_ctrl = (wr.data & udl_pkg::CTRL_SW_MASK)
                    | (ctrl & wr.data & udl_pkg::CTRL_ST_MASK); // R15
        udl_pkg::OFF_NODE_ID:
          next_node_id = wr.data & udl_pkg::NODE_MASK; // R17
        udl_pkg::OFF_EP_ZERO:
          next_ep0 = (wr.data & udl_pkg::EP0_SW_MASK)
                   | (ep0 & wr.data & udl_pkg::EP0_KEEP); // R22
        default: ;
      endcase
    end
    if (flags[udl_pkg::FB_FAULT] && !next_flags[udl_pkg::FB_FAULT]) begin
      next_status[2:0] = udl_pkg::FAULT_NONE; // R21
    end
    if (link_ev.sof) begin
      next_flags[udl_pkg::FB_SOF] = 1'b1; // R8
    end
    if (link_ev.error) begin
      next_flags[udl_pkg::FB_FAULT] = 1'b1; // R2
      next_status[2:0] = link_ev.err_code; // R20
    end
    if (link_ev.epn_ok) begin
      next_status[5]   = link_ev.epn_dir; // R19
      next_status[4:3] = link_ev.epn_index; // R19
    end
    if (link_ev.ep0_ok) begin
      if (link_ev.ep0_token == udl_pkg::TOKEN_SETUP
          && ep0[udl_pkg::EB_DONE]) begin
        // Status is kept so software still sees the pending transfer
        next_flags[udl_pkg::FB_SETUP_OVERFLOW_FLAG] = 1'b1; // R1
      end else begin
        next_status[7:6] = link_ev.ep0_token; // R18
        next_status[4:3] = udl_pkg::EP_INDEX0; // R19
        next_ep0[udl_pkg::EB_DONE] = 1'b1; // R22
      end
    end
    if (sleep_req) begin
      next_flags[udl_pkg::FB_IDLE] = 1'b1; // R3
    end
    if (ctrl[udl_pkg::CB_FORCED_SLEEP] && link_ev.activity) begin
      next_flags[udl_pkg::FB_WAKE] = 1'b1; // R5
      next_ctrl[udl_pkg::CB_FORCED_SLEEP] = 1'b0; // R15
    end
    if (link_ev.resume_start) begin
      next_ctrl[udl_pkg::CB_RSM] = 1'b1; // R12
    end
    if (link_ev.bus_reset) begin
      next_ctrl[udl_pkg::CB_RSTSEEN] = 1'b1; // R12
    end
    // Release of the forced reset counts as a reset event
    if (link_ev.bus_reset
        || (ctrl[udl_pkg::CB_FORCE_BUS_RESET] && !next_ctrl[udl_pkg::CB_FORCE_BUS_RESET])) begin
      next_flags[udl_pkg::FB_RESET] = 1'b1; // R6 R16
    end
    if (usb_reset_now) begin
      next_node_id = udl_pkg::REG_RESET; // R7
      next_ep0     = next_ep0 & udl_pkg::EP0_KEEP; // R7 R22
    end
    next_link_reset = link_ev.bus_reset || next_ctrl[udl_pkg::CB_FORCE_BUS_RESET]; // R16
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags      <= udl_pkg::REG_RESET;
      enable     <= udl_pkg::REG_RESET;
      ctrl       <= udl_pkg::CTRL_RESET; // R11
      node_id    <= udl_pkg::REG_RESET;
      status     <= udl_pkg::REG_RESET;
      ep0        <= udl_pkg::REG_RESET;
      link_reset <= 1'b0;
    end else begin
      flags      <= next_flags;
      enable     <= next_enable;
      ctrl       <= next_ctrl;
      node_id    <= next_node_id;
      status     <= next_status;
      ep0        <= next_ep0;
      link_reset <= next_link_reset; // R7
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_setup_overrun: assert property (
    link_ev.ep0_ok && link_ev.ep0_token == udl_pkg::TOKEN_SETUP
    && ep0[udl_pkg::EB_DONE] && !link_ev.epn_ok && !link_ev.error
    && !(wr.en && wr.addr == udl_pkg::OFF_IRQ_FLAG)
    |=> flags[udl_pkg::FB_SETUP_OVERFLOW_FLAG] && $stable(status)) // R1
    else $error("setup overrun not flagged or status changed");
  a_fault_set: assert property (
    link_ev.error |=> flags[udl_pkg::FB_FAULT]
    && status[2:0] == $past(link_ev.err_code)) // R2
    else $error("bus error not recorded");
  a_wake_flag: assert property (
    ctrl[udl_pkg::CB_FORCED_SLEEP] && link_ev.activity
    |=> flags[udl_pkg::FB_WAKE] && !ctrl[udl_pkg::CB_FORCED_SLEEP]) // R5
    else $error("wake from suspend not handled");
  a_reset_flag: assert property (
    link_ev.bus_reset |=> flags[udl_pkg::FB_RESET]
    && node_id == 8'h00 && link_reset) // R6
    else $error("bus reset not handled");
  a_sof_flag: assert property (
    link_ev.sof |=> flags[udl_pkg::FB_SOF]) // R8
    else $error("start of frame not flagged");
  a_irq_request: assert property (
    !irq_global_mask && flags[udl_pkg::FB_SOF]
    && enable[udl_pkg::FB_SOF] |-> irq_usb && !irq_wake
    || flags[udl_pkg::FB_WAKE] && enable[udl_pkg::FB_WAKE]) // R10
    else $error("interrupt request missing");
  a_ctrl_reset: assert property (
    !$past(aresetn) |-> ctrl == udl_pkg::CTRL_RESET) // R11
    else $error("control register reset value wrong");
  a_force_bus_reset_release: assert property (
    $fell(ctrl[udl_pkg::CB_FORCE_BUS_RESET]) |-> flags[udl_pkg::FB_RESET]) // R16
    else $error("forced reset release not flagged");
  a_fault_clear: assert property (
    $fell(flags[udl_pkg::FB_FAULT]) |-> status[2:0] == 3'h0) // R21
    else $error("fault code not cleared with flag");
  a_done_set: assert property ( // R22 R24
    link_ev.ep0_ok && !ep0[udl_pkg::EB_DONE]
    |=> ep0[udl_pkg::EB_DONE] && xfer_ok_flag)
    else $error("endpoint 0 done not set");
  a_node_top: assert property (
    node_id[7] == 1'b0 ##1 node_id[7] == 1'b0) // R17
    else $error("address top bit set");

  // Wake line alone must reach a halted core
  a_wake_line: assert property ( // R5
    !irq_global_mask && flags[udl_pkg::FB_WAKE] && enable[udl_pkg::FB_WAKE]
    |-> irq_wake)
    else $error("wake line missing");

  a_mask_blocks: assert property ( // R10
    irq_global_mask |-> !irq_usb && !irq_wake)
    else $error("interrupt while masked");

  // Forced reset is a level, so its hold is checked, not an edge
  a_force_bus_reset_hold: assert property ( // R7 R16
    ctrl[udl_pkg::CB_FORCE_BUS_RESET] |-> link_reset ##1 node_id == 8'h00)
    else $error("forced reset not held");

  // Bit 7 survives: a pending transfer outlives a bus reset
  a_ep0_clear: assert property ( // R7 R22
    usb_reset_now |=> (ep0 & udl_pkg::EP0_SW_MASK) == 8'h00)
    else $error("endpoint 0 controls kept");

  a_idle_flag: assert property ( // R3
    sleep_req |=> flags[udl_pkg::FB_IDLE])
    else $error("sleep request lost");

  c_setup_overrun: cover property (flags[udl_pkg::FB_SETUP_OVERFLOW_FLAG]);
  c_wake: cover property (irq_wake);
  c_idle: cover property (sleep_req);
  c_force_bus_reset: cover property ($fell(ctrl[udl_pkg::CB_FORCE_BUS_RESET]));
  c_xfer_ok: cover property (xfer_ok_flag);
endmodule : udl_link_ctrl
`default_nettype wire

// file: sim/udl_host_model.sv
// Behavioural USB host model that drives link events into the block
`timescale 1ns/10ps
`default_nettype none
module udl_host_model (
  input  wire logic             aclk,
  output udl_pkg::udl_link_ev_t link_ev
);
  initial link_ev = '0;
  // Kinds: 0 sof, 1 reset, 2 resume, 3 activity, 4 ep0, 5 epn, else error
  task automatic fire(input int k, input logic [2:0] d);
    udl_pkg::udl_link_ev_t e;
    e = {5'h0, link_ev.idle, 1'b0, d[1:0], 1'b0, d[1:0], d[2], 1'b0, d};
    case (k)
      0: e.sof = 1'b1;
      1: e.bus_reset = 1'b1;
      2: e.resume_start = 1'b1;
      3: e.activity = 1'b1;
      4: e.ep0_ok = 1'b1;
      5: e.epn_ok = 1'b1;
      default: e.error = 1'b1;
    endcase
    @(posedge aclk);
    link_ev <= e;
    @(posedge aclk);
    // Qualifiers go stale once the strobe drops, so show them inverted
    link_ev <= (~e & 17'h0377) | (e & 17'h0800);
  endtask : fire
  task automatic set_idle(input logic v);
    @(posedge aclk);
    link_ev.idle <= v;
  endtask : set_idle
endmodule : udl_host_model
`default_nettype wire

// file: sim/usb_device_link_control_test.sv
// Self-checking bench for the USB device link control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
  checked++; \
  if ((a) !== (e)) begin \
    bad_count++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (e)); \
  end \
end
module usb_device_link_control_test;
  // Short idle limit keeps the sleep tests quick
  localparam int unsigned LIM = 20;
  localparam logic [7:0]  FL = udl_pkg::OFF_IRQ_FLAG;
  localparam logic [7:0]  EN = udl_pkg::OFF_IRQ_EN;
  localparam logic [7:0]  CT = udl_pkg::OFF_LINK_CTRL;
  localparam logic [7:0]  ND = udl_pkg::OFF_NODE_ID;
  localparam logic [7:0]  ST = udl_pkg::OFF_LINK_STAT;
  localparam logic [7:0]  E0 = udl_pkg::OFF_EP_ZERO;
  logic                   aclk, aresetn, awvalid, wvalid, bready, arvalid;
  logic                   rready, gmask, odone, awready, wready, bvalid;
  logic                   arready, rvalid, irq_usb, irq_wake, reg_off;
  logic                   res_drv, idle_sleep_request, lrst;
  logic [udl_pkg::AW-1:0] awaddr, araddr;
  logic [31:0]            wdata, rdata, d;
  logic [3:0]             wstrb;
  logic [1:0]             bresp, rresp, r;
  logic [6:0]             naddr;
  logic [2:0]             codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [1:0]             toks [3] = '{2'h3, 2'h2, 2'h0};
  udl_pkg::udl_link_ev_t  ev;
  int                     bad_count, checked, cyc;
  udl_host_model host (.aclk(aclk), .link_ev(ev));
  udl_link_ctrl #(.IDLE_LIMIT(LIM)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link_ev(ev), .ep_other_done(odone),
    .irq_global_mask(gmask), .irq_usb(irq_usb), .irq_wake(irq_wake),
    .regulator_off(reg_off), .resume_drive(res_drv),
    .suspend_active(idle_sleep_request), .link_reset(lrst), .node_addr(naddr)
  );
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic report_and_stop();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // Address and data go out together; each drops once its ready is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] er = udl_pkg::RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK({r, d}, {udl_pkg::RESP_OKAY, 24'h0, e})
  endtask : rchk
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, gmask, odone, bad_count, checked} = '0;
    wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(CT, 8'h06);
    `CHK({reg_off, idle_sleep_request}, 2'b11)
    rchk(FL, 8'h00);
    rd(8'h18);
    `CHK({r, d}, {udl_pkg::RESP_SLVERR, 32'h0})
    wr(ST, 8'hFF, udl_pkg::RESP_SLVERR);
    wr(EN, 8'hFF);
    rchk(EN, 8'hBF);
    wr(EN, 8'h01);
    host.fire(0, 3'h0);
    rchk(FL, 8'h01);
    `CHK(irq_usb, 1'b1)
    gmask <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(irq_usb, 1'b0)
    gmask <= 1'b0;
    wr(FL, 8'hFF);
    rchk(FL, 8'h01);
    wr(FL, 8'hFE);
    rchk(FL, 8'h00);
    $display("test reset and flags done");
    foreach (codes[i]) begin
      host.fire(6, codes[i]);
      rchk(FL, 8'h10);
      rchk(ST, {5'h0, codes[i]});
      wr(FL, 8'hEF);
      rchk(ST, 8'h00);
    end
    foreach (toks[i]) begin
      host.fire(4, {1'b0, toks[i]});
      rchk(E0, 8'h80);
      rchk(ST, {toks[i], 6'h0});
      wr(E0, 8'h00);
    end
    host.fire(4, 3'h0);
    host.fire(4, 3'h3);
    rchk(FL, 8'hA0);
    rchk(ST, 8'h00);
    wr(E0, 8'h00);
    wr(FL, 8'hDF);
    odone <= 1'b1;
    rchk(FL, 8'h80);
    odone <= 1'b0;
    host.fire(5, 3'h5);
    rchk(ST, 8'h28);
    host.fire(5, 3'h2);
    rchk(ST, 8'h10);
    $display("test status done");
    wr(ND, 8'hFF);
    rchk(ND, 8'h7F);
    `CHK(naddr, 7'h7F)
    wr(E0, 8'h77);
    host.fire(1, 3'h0);
    rchk(FL, 8'h02);
    rchk(ND, 8'h00);
    rchk(E0, 8'h00);
    rchk(CT, 8'h46);
    wr(CT, 8'h00);
    `CHK({reg_off, idle_sleep_request}, 2'b00)
    wr(FL, 8'hFD);
    wr(ND, 8'h05);
    wr(CT, 8'h01);
    rchk(ND, 8'h00);
    `CHK(lrst, 1'b1)
    wr(CT, 8'h00);
    rchk(FL, 8'h02);
    wr(FL, 8'hFD);
    $display("test usb reset done");
    host.set_idle(1'b1);
    repeat (LIM + 5) @(posedge aclk);
    rchk(FL, 8'h08);
    host.set_idle(1'b0);
    wr(FL, 8'hF7);
    wr(CT, 8'h02);
    `CHK(idle_sleep_request, 1'b1)
    host.set_idle(1'b1);
    repeat (LIM + 5) @(posedge aclk);
    rchk(FL, 8'h00);
    host.set_idle(1'b0);
    wr(EN, 8'h04);
    host.fire(3, 3'h0);
    rchk(FL, 8'h04);
    `CHK(irq_wake, 1'b1)
    rchk(CT, 8'h00);
    wr(CT, 8'h08);
    `CHK(res_drv, 1'b1)
    host.fire(2, 3'h0);
    rchk(CT, 8'h88);
    $display("test sleep and resume done");
    report_and_stop();
  end
endmodule : usb_device_link_control_test
`default_nettype wire
